// ### src/scf_top.v
/*
 Third_order_select / chopped sinc4 decimation filter with conversion sequencing,
 register port and a 16-word result buffer.
 Assumes one modulator bit per master clock tick (ce high), inputs
 synchronous to mclk, and a result sink that may stall.
*/
// The register offsets and the strobed register port are this design's own decisions.
// Operation
// - Third_order_select channel change resets, settles, then streams
// - Third_order_select keeps streaming at programmed rate after steps
// - Zero-latency bit 11 settles every conversion fully
// - Sequencer enable forces zero-latency operation
// - Third_order_select zero-latency period is three base periods
// - Zero-latency channel change keeps constant output rate
// - Asynchronous step gives one unsettled zero-latency result
// - Dual-notch select adds sixty hertz notch
// - Chop swaps input polarity after each settled conversion
// - Chop averages successive opposite-polarity conversions
// - Chop sinc4 period four base periods, divider 1-1023
// - Chop sinc4 settling is two output periods
// - Chop sinc4 channel change resets and settles fully
// - Chop sinc4 keeps streaming after input steps
// - Chop averaging adds notches at odd half-rate multiples
// - Dual-notch under chop keeps output rate
// - Third-order select picks third_order_select over sinc4
// - Unchopped third_order_select period is one base period outside zero latency
`include "scf_defines.vh"

module scf_fifo #(
    parameter W     = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // Clock and reset
    input  wire          mclk,
    input  wire          srst,
    input  wire          ce,
    // Fill side
    input  wire          in_valid,
    output wire          in_ready,
    input  wire [W-1:0]  in_data,
    // Drain side
    output wire          out_valid,
    input  wire          out_ready,
    output wire [W-1:0]  out_data,
    // Fill level
    output wire [AW:0]   level
);
    localparam [AW:0] FULL = DEPTH;
    localparam [AW:0] ONE  = 1;
    localparam [AW-1:0] P1 = 1;

    reg  [W-1:0]  mem [0:DEPTH-1];
    reg  [AW-1:0] wr_ptr;
    reg  [AW-1:0] rd_ptr;
    reg  [AW:0]   count;
    wire          push;
    wire          pop;

    assign in_ready  = (count != FULL);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign level     = count;
    assign push      = ce & in_valid & in_ready;
    assign pop       = ce & out_valid & out_ready;

    always @(posedge mclk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge mclk)
    begin
        if (srst)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + P1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + P1;
            end
            if (push & ~pop)
            begin
                count <= count + ONE;
            end
            else if (pop & ~push)
            begin
                count <= count - ONE;
            end
        end
    end
endmodule // scf_fifo

module scf_top (
    // Clock, reset, clock enable (one modulator tick per ce)
    input  wire                     mclk,
    input  wire                     srst,
    input  wire                     ce,
    // Register port
    input  wire [`SCF_ADDR_W-1:0]   reg_addr,
    input  wire [`SCF_DATA_W-1:0]   reg_wdata,
    input  wire                     reg_wr,
    input  wire                     reg_rd,
    output reg  [`SCF_DATA_W-1:0]   reg_rdata,
    // Modulator bitstream
    input  wire                     mod_bit,
    output wire                     mod_ready,
    // Front end control
    input  wire                     chan_change,
    input  wire                     seq_en,
    output reg                      mod_reset,
    output wire                     chop_swap,
    // Conversion results
    output wire                     res_valid,
    input  wire                     res_ready,
    output wire [`SCF_W-1:0]        res_data
);
    localparam ST_SETTLE = 1'b0;
    localparam ST_RUN    = 1'b1;

    reg  [`SCF_DATA_W-1:0]  mode;
    reg  [`SCF_PH_W-1:0]    ph;
    reg  [`SCF_ORD_W-1:0]   per;
    reg                     st;
    reg                     pol;
    reg                     have_prev;
    reg  [`SCF_W-1:0]       prev;
    reg  [`SCF_W-1:0]       snap;
    reg  [`SCF_W-1:0]       integ [0:`SCF_NINT-1];
    reg  [`SCF_W-1:0]       dly   [0:`SCF_NCOMB-1];
    wire [`SCF_W-1:0]       cin   [0:`SCF_NCOMB];

    wire [`SCF_FS_W-1:0]    fs_raw;
    wire [`SCF_FS_W-1:0]    fs_eff;
    wire [`SCF_PH_W-1:0]    p_len;
    wire [`SCF_PH_W-1:0]    d60;
    wire                    zl;
    wire                    chop;
    wire                    rej;
    wire [`SCF_ORD_W-1:0]   ord;
    wire                    mode_wr;
    wire                    restart;
    wire                    ph_last;
    wire                    conv_done;
    wire                    conv_clr;
    wire                    emit_now;
    wire                    stall;
    wire                    adv;
    wire                    fclr;
    wire [`SCF_W-1:0]       x_in;
    wire [`SCF_W-1:0]       tap;
    wire [`SCF_W-1:0]       fin;
    wire [`SCF_W-1:0]       sres;
    wire [`SCF_W:0]         sum2;
    wire [`SCF_W-1:0]       push_data;
    wire                    fifo_in_ready;
    wire [`SCF_FIFO_AW:0]   fifo_level;

    // Mode decode
    assign fs_raw  = mode[`SCF_FS_MSB:`SCF_FS_LSB];
    assign fs_eff  = (fs_raw == {`SCF_FS_W{1'b0}}) ? `SCF_FS_MIN : fs_raw;
    assign p_len   = {fs_eff, `SCF_PH_PAD};
    assign d60     = p_len / `SCF_D60_DIV;
    assign zl      = mode[`SCF_ZL_BIT] | seq_en;
    assign chop    = mode[`SCF_CHOP_BIT];
    assign rej     = mode[`SCF_REJ_BIT];
    assign ord     = mode[`SCF_THIRD_ORDER_SELECT_BIT] ? `SCF_ORD3 : `SCF_ORD4;

    // Sequencing
    assign mode_wr   = reg_wr & (reg_addr == `SCF_REG_MODE);
    assign restart   = chan_change | mode_wr;
    assign ph_last   = (ph == p_len - `SCF_PH_ONE);
    assign conv_done = ph_last & (per == ord - `SCF_PER_ONE);
    assign conv_clr  = conv_done & (zl | chop);
    assign emit_now  = ph_last & ((st == ST_RUN) | (per == ord - `SCF_PER_ONE))
                       & ~(chop & ~have_prev);
    assign stall     = emit_now & ~fifo_in_ready;
    assign adv       = ce & ~restart & ~stall;
    assign fclr      = ce & (restart | (adv & conv_clr));
    assign mod_ready = fifo_in_ready;
    assign chop_swap = pol;

    // Filter datapath: integrators, optional 60 Hz comb, then combs
    assign x_in = mod_bit ? {{(`SCF_W-1){1'b0}}, 1'b1} : {`SCF_W{1'b1}};
    assign tap  = rej ? integ[ord] : integ[ord - `SCF_PER_ONE];
    assign cin[0] = rej ? (tap - snap) : tap;

    genvar gi;
    generate
        for (gi = 0; gi < `SCF_NINT; gi = gi + 1)
        begin : g_int
            always @(posedge mclk)
            begin
                if (srst | fclr)
                begin
                    integ[gi] <= {`SCF_W{1'b0}};
                end
                else if (adv)
                begin
                    // Stage two adds the live sample so a cleared filter settles in ord periods
                    integ[gi] <= integ[gi] + ((gi == 0) ? x_in :
                                 (gi == 1) ? integ[0] + x_in : integ[(gi == 0) ? 0 : gi - 1]);
                end
            end
        end
        for (gi = 0; gi < `SCF_NCOMB; gi = gi + 1)
        begin : g_comb
            assign cin[gi+1] = cin[gi] - dly[gi];
            always @(posedge mclk)
            begin
                if (srst | fclr)
                begin
                    dly[gi] <= {`SCF_W{1'b0}};
                end
                else if (adv & ph_last)
                begin
                    dly[gi] <= cin[gi];
                end
            end
        end
    endgenerate

    assign fin       = (ord == `SCF_ORD3) ? cin[`SCF_ORD3] : cin[`SCF_ORD4];
    assign sres      = (chop & pol) ? (~fin + {{(`SCF_W-1){1'b0}}, 1'b1}) : fin;
    assign sum2      = {sres[`SCF_W-1], sres} + {prev[`SCF_W-1], prev};
    assign push_data = chop ? sum2[`SCF_W:1] : fin;

    // Sample of the comb input tap (integ[ord] when rej is set) 5/6 period before each period end
    always @(posedge mclk)
    begin
        if (srst | fclr)
        begin
            snap <= {`SCF_W{1'b0}};
        end
        else if (adv & (ph == d60 - `SCF_PH_ONE))
        begin
            snap <= tap + {`SCF_W{1'b0}};
        end
    end

    // Sequencer state
    always @(posedge mclk)
    begin
        if (srst)
        begin
            mode      <= `SCF_MODE_RST;
            ph        <= {`SCF_PH_W{1'b0}};
            per       <= {`SCF_ORD_W{1'b0}};
            st        <= ST_SETTLE;
            pol       <= 1'b0;
            have_prev <= 1'b0;
            prev      <= {`SCF_W{1'b0}};
            mod_reset <= 1'b0;
        end
        else if (ce)
        begin
            mod_reset <= restart;
            if (mode_wr)
            begin
                mode <= reg_wdata;
            end
            if (restart)
            begin
                ph        <= {`SCF_PH_W{1'b0}};
                per       <= {`SCF_ORD_W{1'b0}};
                st        <= ST_SETTLE;
                pol       <= 1'b0;
                have_prev <= 1'b0;
            end
            else if (~stall)
            begin
                if (ph_last)
                begin
                    ph <= {`SCF_PH_W{1'b0}};
                    if (conv_clr)
                    begin
                        per <= {`SCF_ORD_W{1'b0}};
                        if (chop)
                        begin
                            pol       <= ~pol;
                            prev      <= sres;
                            have_prev <= 1'b1;
                        end
                    end
                    else if (st == ST_SETTLE)
                    begin
                        if (conv_done)
                        begin
                            st <= ST_RUN;
                        end
                        else
                        begin
                            per <= per + `SCF_PER_ONE;
                        end
                    end
                end
                else
                begin
                    ph <= ph + `SCF_PH_ONE;
                end
            end
        end
    end

    // Register read port
    always @(posedge mclk)
    begin
        if (srst)
        begin
            reg_rdata <= {`SCF_DATA_W{1'b0}};
        end
        else if (ce)
        begin
            reg_rdata <= {`SCF_DATA_W{1'b0}};
            if (reg_rd & (reg_addr == `SCF_REG_MODE))
            begin
                reg_rdata <= mode;
            end
            else if (reg_rd & (reg_addr == `SCF_REG_STAT))
            begin
                reg_rdata[`SCF_ST_PREV_BIT] <= have_prev;
                reg_rdata[`SCF_ST_RUN_BIT]  <= st;
                reg_rdata[`SCF_ST_POL_BIT]  <= pol;
                reg_rdata[`SCF_ST_LVL_MSB:`SCF_ST_LVL_LSB] <= fifo_level;
            end
        end
    end

    scf_fifo #(
        .W     (`SCF_W),
        .DEPTH (`SCF_FIFO_DEPTH),
        .AW    (`SCF_FIFO_AW)
    ) u_fifo (
        .mclk      (mclk),
        .srst      (srst | (ce & restart)),
        .ce        (ce),
        .in_valid  (emit_now & ~restart),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data),
        .out_valid (res_valid),
        .out_ready (res_ready),
        .out_data  (res_data),
        .level     (fifo_level)
    );
endmodule // scf_top

// ### shared/scf_defines.vh
/*
 Constants for the sinc conversion sequencer: register map, mode field
 positions, reset values, filter widths and result buffer size.
 Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef SCF_DEFINES_VH
`define SCF_DEFINES_VH

// Register map
`define SCF_ADDR_W      8
`define SCF_DATA_W      32
`define SCF_REG_MODE    8'h00
`define SCF_REG_STAT    8'h04
`define SCF_MODE_RST    32'h0000_0060

// Mode register fields
`define SCF_FS_MSB      9
`define SCF_FS_LSB      0
`define SCF_ZL_BIT      11
`define SCF_REJ_BIT     13
`define SCF_THIRD_ORDER_SELECT_BIT   15
`define SCF_CHOP_BIT    23

// Status register fields
`define SCF_ST_PREV_BIT 0
`define SCF_ST_RUN_BIT  1
`define SCF_ST_POL_BIT  2
`define SCF_ST_LVL_LSB  4
`define SCF_ST_LVL_MSB  8

// Timing: one base period is 1024 master clocks times the divider
`define SCF_FS_W        10
`define SCF_PH_W        20
`define SCF_FS_MIN      10'h001
`define SCF_PH_PAD      10'h000
`define SCF_PH_ONE      20'h0_0001
`define SCF_D60_DIV     20'h0_0006
`define SCF_ORD_W       3
`define SCF_ORD3        3'h3
`define SCF_ORD4        3'h4
`define SCF_PER_ONE     3'h1

// Filter datapath
`define SCF_W           104
`define SCF_NINT        5
`define SCF_NCOMB       4

// Result buffer
`define SCF_FIFO_DEPTH  16
`define SCF_FIFO_AW     4

`endif

// ### sim/scf_mod_model.sv
/*
 Modulator and input switch model for the far side of scf_top.
 Assumes a full-scale DC input whose sign is chosen by level.
*/
module scf_mod_model (
    // Input sign and switch
    input  wire logic level,
    input  wire logic chop_swap,
    // Bitstream
    output wire logic mod_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    // Swapped input pins invert the bitstream
    assign mod_bit = level ^ chop_swap;
endmodule // scf_mod_model

// ### sim/scf_top_assertions.sv
/*
 Port checker for scf_top.
 Assumes the divider is 1 whenever results are expected.
*/
`include "scf_defines.vh"
module scf_checker (
    // Clock and reset
    input wire logic         mclk,
    input wire logic         srst,
    input wire logic         ce,
    // Register port
    input wire logic [7:0]   reg_addr,
    input wire logic [31:0]  reg_wdata,
    input wire logic         reg_wr,
    input wire logic         reg_rd,
    input wire logic [31:0]  reg_rdata,
    // Front end and results
    input wire logic         chan_change,
    input wire logic         mod_reset,
    input wire logic         mod_ready,
    input wire logic         chop_swap,
    input wire logic         res_valid,
    input wire logic         res_ready,
    input wire logic [103:0] res_data
);
    reg [19:0] since_rst;
    reg [19:0] swap_gap;
    reg        last_swap;
    always @(posedge mclk)
    begin
        last_swap <= chop_swap;
        if (srst || mod_reset)
            since_rst <= 20'h0_0000;
        else if (ce && since_rst != 20'hF_FFFF)
            since_rst <= since_rst + 20'h0_0001;
        if (srst || mod_reset || chop_swap != last_swap)
            swap_gap <= 20'h0_0000;
        else if (ce && swap_gap != 20'hF_FFFF)
            swap_gap <= swap_gap + 20'h0_0001;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    AST_CHAN_RESTART:
        assert property (ce && chan_change |=> mod_reset) else $error("no restart pulse");
    AST_MODE_RESTART:
        assert property (ce && reg_wr && reg_addr == `SCF_REG_MODE |=> mod_reset)
        else $error("mode write did not restart");
    AST_FLUSH:
        assert property (mod_reset |=> !res_valid && !chop_swap) else $error("restart left state");
    AST_SETTLE:
        assert property (res_valid |-> since_rst >= 20'h0_0BFF) else $error("result too early");
    AST_SWAP_GAP:
        assert property ($rose(chop_swap) |-> swap_gap >= 20'h0_0BB8)
        else $error("polarity swapped before settling");
    AST_STALL_HOLD:
        assert property (!mod_ready && !res_ready && !chan_change && !reg_wr |=> !mod_ready)
        else $error("stall released while full");
    AST_RES_HOLD:
        assert property (res_valid && !res_ready && !chan_change && !reg_wr
                         |=> res_valid && $stable(res_data)) else $error("result lost");
    AST_READBACK:
        assert property (ce && reg_wr && reg_addr == `SCF_REG_MODE ##1
                         ce && reg_rd && reg_addr == `SCF_REG_MODE
                         |=> reg_rdata == $past(reg_wdata, 2)) else $error("mode readback");
    AST_RDATA_IDLE:
        assert property (!reg_rd |=> reg_rdata == 32'h0000_0000) else $error("read data not idle");
endmodule // scf_checker
bind scf_top scf_checker chk_u (.mclk(mclk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .chan_change(chan_change), .mod_reset(mod_reset), .mod_ready(mod_ready),
    .chop_swap(chop_swap), .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));

// ### sim/scf_top_tb.sv
/*
 Testbench for scf_top: register tasks, result timing and values.
 Assumes the modulator model and the bound checker are compiled first.
*/
`include "scf_defines.vh"
`define SCF_CHK(got, exp) \
    begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module scf_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [103:0] S3 = 104'h4000_0000;
    localparam [103:0] S4 = 104'h100_0000_0000;
    localparam [31:0]  M3 = 32'h0000_8001;
    localparam [31:0]  ZL = 32'h0000_0800;
    localparam [31:0]  CH = 32'h0080_0001;
    localparam [31:0]  RJ = 32'h0000_2000;
    logic         mclk = 1'b0;
    logic         srst = 1'b1;
    logic         ce = 1'b1;
    logic [7:0]   reg_addr = 8'h00;
    logic [31:0]  reg_wdata = 32'h0000_0000;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic         chan_change = 1'b0;
    logic         seq_en = 1'b0;
    logic         res_ready = 1'b1;
    logic         level = 1'b1;
    wire  [31:0]  reg_rdata;
    wire          mod_bit, mod_ready, mod_reset, chop_swap, res_valid;
    wire  [103:0] res_data;
    int           fail_count = 0;
    int           cmp_count = 0;
    int           cyc = 0;
    int           gap;
    logic [103:0] dat;
    logic [31:0]  rv;
    logic         pol;
    scf_top dut_u (.mclk(mclk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .mod_bit(mod_bit), .mod_ready(mod_ready), .chan_change(chan_change), .seq_en(seq_en),
        .mod_reset(mod_reset), .chop_swap(chop_swap), .res_valid(res_valid),
        .res_ready(res_ready), .res_data(res_data));
    scf_mod_model mod_u (.level(level), .chop_swap(chop_swap), .mod_bit(mod_bit));
    always #5 mclk = ~mclk;
    task conclude;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
            if (fail_count == 0 && cmp_count > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            fail_count++;
            conclude();
        end
    end
    // Bus tasks are entered just after a rising edge
    task wr(input logic [7:0] a, input logic [31:0] d);
        begin
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge mclk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input logic [7:0] a);
        begin
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge mclk);
            reg_rd <= 1'b0;
            #1;
            rv = reg_rdata;
        end
    endtask
    task pulse_chan;
        begin
            chan_change <= 1'b1;
            @(posedge mclk);
            chan_change <= 1'b0;
        end
    endtask
    // Cycles until the next result, which is popped at the following edge
    task wait_res;
        begin
            gap = 0;
            do
            begin
                @(posedge mclk);
                #1;
                gap++;
            end while (res_valid !== 1'b1 && gap < 20000);
            dat = res_data;
        end
    endtask
    initial
    begin
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        #1;
        rd(`SCF_REG_MODE);
        `SCF_CHK(rv, `SCF_MODE_RST)
        rd(8'h08);
        `SCF_CHK(rv, 32'h0000_0000)
        $display("test registers done");
        wr(`SCF_REG_MODE, M3);
        wait_res;
        `SCF_CHK(gap, 3072)
        `SCF_CHK(dat, S3)
        repeat (2)
        begin
            wait_res;
            `SCF_CHK(gap, 1024)
        end
        repeat (500) @(posedge mclk);
        pulse_chan;
        wait_res;
        `SCF_CHK(gap, 3072)
        repeat (500) @(posedge mclk);
        level <= 1'b0;
        repeat (3) wait_res;
        `SCF_CHK(dat === -S3, 1'b0)
        wait_res;
        `SCF_CHK(dat, -S3)
        $display("test third_order_select stream done");
        level <= 1'b1;
        wr(`SCF_REG_MODE, M3 | ZL);
        rd(`SCF_REG_MODE);
        `SCF_CHK(rv, M3 | ZL)
        wait_res;
        `SCF_CHK(dat, S3)
        wait_res;
        `SCF_CHK(gap, 3072)
        repeat (1000) @(posedge mclk);
        level <= 1'b0;
        wait_res;
        `SCF_CHK(dat === -S3, 1'b0)
        wait_res;
        `SCF_CHK(dat, -S3)
        `SCF_CHK(gap, 3072)
        repeat (1000) @(posedge mclk);
        pulse_chan;
        wait_res;
        `SCF_CHK(gap, 3072)
        $display("test zero latency done");
        level <= 1'b1;
        seq_en <= 1'b1;
        wr(`SCF_REG_MODE, M3);
        wait_res;
        ce <= 1'b0;
        repeat (100) @(posedge mclk);
        ce <= 1'b1;
        wait_res;
        `SCF_CHK(gap, 3072)
        seq_en <= 1'b0;
        $display("test sequencer done");
        wr(`SCF_REG_MODE, CH | RJ);
        wait_res;
        `SCF_CHK(gap, 8192)
        pol = chop_swap;
        wait_res;
        `SCF_CHK(gap, 4096)
        `SCF_CHK(chop_swap, ~pol)
        pulse_chan;
        wr(`SCF_REG_MODE, CH);
        wait_res;
        `SCF_CHK(gap, 8192)
        `SCF_CHK(dat, S4)
        wait_res;
        `SCF_CHK(gap, 4096)
        `SCF_CHK(dat, S4)
        $display("test chop done");
        res_ready <= 1'b0;
        wr(`SCF_REG_MODE, M3);
        gap = 0;
        while (mod_ready !== 1'b0 && gap < 25000)
        begin
            @(posedge mclk);
            #1;
            gap++;
        end
        repeat (1100) @(posedge mclk);
        #1;
        `SCF_CHK(mod_ready, 1'b0)
        rd(`SCF_REG_STAT);
        `SCF_CHK(rv[8:4], 5'h10)
        `SCF_CHK(res_data, S3)
        res_ready <= 1'b1;
        wait_res;
        `SCF_CHK(gap, 1)
        `SCF_CHK(dat, S3)
        $display("test buffer done");
        conclude();
    end
endmodule // scf_top_tb
